// ### common/psd_params.svh
// constants for the detail status byte bank
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

// command codes of the five detail bytes and of the clear command
`define PSD_CMD_VOUT        8'h7a
`define PSD_CMD_IOUT        8'h7b
`define PSD_CMD_INPUT       8'h7c
`define PSD_CMD_TEMP        8'h7d
`define PSD_CMD_CML         8'h7e
`define PSD_CMD_CLEAR       8'h03

// reset value of every byte
`define PSD_RESET_VALUE     8'h00

// output voltage byte fields
`define PSD_VOUT_OV_FAULT   7
`define PSD_VOUT_UV_WARN    5
`define PSD_VOUT_UV_FAULT   4
// output current byte fields
`define PSD_IOUT_OC_FAULT   7
`define PSD_IOUT_OC_LV      6
`define PSD_IOUT_OC_WARN    5
`define PSD_IOUT_UC_FAULT   4
`define PSD_IOUT_PHASE0     3
`define PSD_IOUT_PHASE1     2
// input byte fields
`define PSD_VIN_OV_FAULT    7
`define PSD_VIN_OV_WARN     6
`define PSD_VIN_UV_WARN     5
`define PSD_VIN_UV_FAULT    4
// temperature byte fields
`define PSD_OT_FAULT        7
`define PSD_OT_WARN         6
`define PSD_UT_WARN         5
`define PSD_UT_FAULT        4
`define PSD_TEMP_INT        3
`define PSD_TEMP_EXT_A      2
`define PSD_TEMP_EXT_B      1
// communication byte fields
`define PSD_CML_BAD_CMD     7
`define PSD_CML_BAD_DATA    6
`define PSD_CML_PEC         5
`define PSD_CML_OTHER       1

// status word summary bit
`define PSD_WORD_OTHER      9

// masks of implemented bits
`define PSD_MASK_VOUT       8'hb0
`define PSD_MASK_IOUT       8'hfc
`define PSD_MASK_INPUT      8'hf0
`define PSD_MASK_TEMP       8'hfe
`define PSD_MASK_CML        8'he2

`endif

// ### common/psd_pkg.sv
// types for the detail status byte bank
package psd_pkg;

    typedef logic [7:0] psd_byte_t;

    typedef enum logic [2:0]
    {
        PSD_SEL_VOUT,
        PSD_SEL_IOUT,
        PSD_SEL_INPUT,
        PSD_SEL_TEMP,
        PSD_SEL_CML,
        PSD_SEL_NONE
    } psd_sel_t;

endpackage

// ### hw/psd_status_bank.sv
// five read-only sticky detail status bytes with command-code read port
`timescale 1ns/10ps
`include "psd_params.svh"

module psd_status_bank
(
    input  wire logic               clk_in,
    input  wire logic               reset_in,
    // output voltage events
    input  wire logic               vout_ov_fault_in,
    input  wire logic               vout_uv_warning_in,
    input  wire logic               vout_uv_fault_in,
    // output current events
    input  wire logic               iout_oc_fault_in,
    input  wire logic               iout_low_voltage_in,
    input  wire logic               iout_oc_warning_in,
    input  wire logic               iout_uc_fault_in,
    input  wire logic               phase0_fault_in,
    input  wire logic               phase1_fault_in,
    // input supply events
    input  wire logic               vin_ov_fault_in,
    input  wire logic               vin_ov_warning_in,
    input  wire logic               vin_uv_warning_in,
    input  wire logic               vin_uv_fault_in,
    // thermal events
    input  wire logic               ot_fault_in,
    input  wire logic               ot_warning_in,
    input  wire logic               ut_warning_in,
    input  wire logic               ut_fault_in,
    input  wire logic               internal_sensor_event_in,
    input  wire logic               external_sensor_a_event_in,
    input  wire logic               external_sensor_b_event_in,
    // communication events from the bus front end
    input  wire logic               bad_command_in,
    input  wire logic               bad_data_in,
    input  wire logic               packet_error_in,
    input  wire logic               other_comm_fault_in,
    // command port from the bus front end
    input  wire logic               cmd_valid_in,
    input  wire logic               cmd_write_in,
    input  wire logic [7:0]         cmd_code_in,
    input  wire logic               vendor_status_any_in,
    output psd_pkg::psd_byte_t      read_data_out,
    output logic                    read_hit_out,
    output logic                    write_refused_out,
    output logic                    status_other_out,
    output psd_pkg::psd_byte_t      output_voltage_status_out,
    output psd_pkg::psd_byte_t      output_current_status_out,
    output psd_pkg::psd_byte_t      input_supply_status_out,
    output psd_pkg::psd_byte_t      thermal_status_out,
    output psd_pkg::psd_byte_t      comm_logic_memory_status_out
);
    import psd_pkg::*;

    psd_byte_t  ev_vout;
    psd_byte_t  ev_iout;
    psd_byte_t  ev_input;
    psd_byte_t  ev_temp;
    psd_byte_t  ev_cml;
    psd_byte_t  output_voltage_status;
    psd_byte_t  output_current_status;
    psd_byte_t  input_supply_status;
    psd_byte_t  thermal_status;
    psd_byte_t  comm_logic_memory_status;
    logic       clear_faults;
    logic       write_to_status;
    psd_sel_t   sel;
    psd_byte_t  read_data;
    psd_byte_t  next_read_data;
    logic       read_hit;
    logic       next_read_hit;
    logic       write_refused;
    logic       next_write_refused;
    logic       status_other;
    logic       next_status_other;

    function automatic psd_sel_t decode(input logic [7:0] code);
        case (code)
            `PSD_CMD_VOUT:  decode = PSD_SEL_VOUT;
            `PSD_CMD_IOUT:  decode = PSD_SEL_IOUT;
            `PSD_CMD_INPUT: decode = PSD_SEL_INPUT;
            `PSD_CMD_TEMP:  decode = PSD_SEL_TEMP;
            `PSD_CMD_CML:   decode = PSD_SEL_CML;
            default:        decode = PSD_SEL_NONE;
        endcase
    endfunction

    // ****************************************
    // event mapping
    // ****************************************
    always_comb
    begin
        ev_vout = 8'h00;
        ev_vout[`PSD_VOUT_OV_FAULT] = vout_ov_fault_in;
        ev_vout[`PSD_VOUT_UV_WARN] = vout_uv_warning_in;
        ev_vout[`PSD_VOUT_UV_FAULT] = vout_uv_fault_in;
        ev_iout = 8'h00;
        ev_iout[`PSD_IOUT_OC_FAULT] = iout_oc_fault_in;
        ev_iout[`PSD_IOUT_OC_LV] = iout_oc_fault_in
                                   & iout_low_voltage_in;
        ev_iout[`PSD_IOUT_OC_WARN] = iout_oc_warning_in;
        ev_iout[`PSD_IOUT_UC_FAULT] = iout_uc_fault_in;
        ev_iout[`PSD_IOUT_PHASE0] = phase0_fault_in;
        ev_iout[`PSD_IOUT_PHASE1] = phase1_fault_in;
        ev_input = 8'h00;
        ev_input[`PSD_VIN_OV_FAULT] = vin_ov_fault_in;
        ev_input[`PSD_VIN_OV_WARN] = vin_ov_warning_in;
        ev_input[`PSD_VIN_UV_WARN] = vin_uv_warning_in;
        ev_input[`PSD_VIN_UV_FAULT] = vin_uv_fault_in;
        ev_temp = 8'h00;
        ev_temp[`PSD_OT_FAULT] = ot_fault_in;
        ev_temp[`PSD_OT_WARN] = ot_warning_in;
        ev_temp[`PSD_UT_WARN] = ut_warning_in;
        ev_temp[`PSD_UT_FAULT] = ut_fault_in;
        ev_temp[`PSD_TEMP_INT] = internal_sensor_event_in;
        ev_temp[`PSD_TEMP_EXT_A] = external_sensor_a_event_in;
        ev_temp[`PSD_TEMP_EXT_B] = external_sensor_b_event_in;
        ev_cml = 8'h00;
        ev_cml[`PSD_CML_BAD_CMD] = bad_command_in;
        ev_cml[`PSD_CML_BAD_DATA] = bad_data_in;
        ev_cml[`PSD_CML_PEC] = packet_error_in;
        ev_cml[`PSD_CML_OTHER] = other_comm_fault_in
                                 | write_to_status;
    end

    // ****************************************
    // command decode
    // ****************************************
    assign sel = decode(cmd_code_in);
    assign clear_faults = cmd_valid_in & cmd_write_in
                          & (cmd_code_in == `PSD_CMD_CLEAR);
    assign write_to_status = cmd_valid_in & cmd_write_in
                             & (sel != PSD_SEL_NONE);

    // ****************************************
    // sticky bytes
    // ****************************************
    psd_sticky_byte #(.MASK(`PSD_MASK_VOUT)) u_vout
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .clear_in  (clear_faults),
        .event_in  (ev_vout),
        .value_out (output_voltage_status)
    );

    psd_sticky_byte #(.MASK(`PSD_MASK_IOUT)) u_iout
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .clear_in  (clear_faults),
        .event_in  (ev_iout),
        .value_out (output_current_status)
    );

    psd_sticky_byte #(.MASK(`PSD_MASK_INPUT)) u_input
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .clear_in  (clear_faults),
        .event_in  (ev_input),
        .value_out (input_supply_status)
    );

    psd_sticky_byte #(.MASK(`PSD_MASK_TEMP)) u_temp
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .clear_in  (clear_faults),
        .event_in  (ev_temp),
        .value_out (thermal_status)
    );

    psd_sticky_byte #(.MASK(`PSD_MASK_CML)) u_cml
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .clear_in  (clear_faults),
        .event_in  (ev_cml),
        .value_out (comm_logic_memory_status)
    );

    // ****************************************
    // read port and summary
    // ****************************************
    always_comb
    begin
        next_read_data = 8'h00;
        next_read_hit = 1'b0;
        if (cmd_valid_in && !cmd_write_in)
        begin
            next_read_hit = (sel != PSD_SEL_NONE);
            case (sel)
                PSD_SEL_VOUT:  next_read_data = output_voltage_status;
                PSD_SEL_IOUT:  next_read_data = output_current_status;
                PSD_SEL_INPUT: next_read_data = input_supply_status;
                PSD_SEL_TEMP:  next_read_data = thermal_status;
                PSD_SEL_CML:   next_read_data = comm_logic_memory_status;
                default:       next_read_data = 8'h00;
            endcase
        end
        next_write_refused = write_to_status;
        next_status_other = (|output_voltage_status)
                            | (|output_current_status)
                            | (|input_supply_status)
                            | (|thermal_status)
                            | (|comm_logic_memory_status)
                            | vendor_status_any_in;
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            read_data <= 8'h00;
            read_hit <= 1'b0;
            write_refused <= 1'b0;
            status_other <= 1'b0;
        end
        else
        begin
            read_data <= next_read_data;
            read_hit <= next_read_hit;
            write_refused <= next_write_refused;
            status_other <= next_status_other;
        end
    end

    assign read_data_out = read_data;
    assign read_hit_out = read_hit;
    assign write_refused_out = write_refused;
    assign status_other_out = status_other;
    assign output_voltage_status_out = output_voltage_status;
    assign output_current_status_out = output_current_status;
    assign input_supply_status_out = input_supply_status;
    assign thermal_status_out = thermal_status;
    assign comm_logic_memory_status_out = comm_logic_memory_status;

endmodule // psd_status_bank

// ### hw/psd_sticky_byte.sv
// one sticky status byte with clear and fixed-zero mask
`timescale 1ns/10ps
`include "psd_params.svh"

module psd_sticky_byte
#(
    parameter logic [7:0] MASK = 8'hff
)
(
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire logic                 clear_in,
    input  wire psd_pkg::psd_byte_t   event_in,
    output psd_pkg::psd_byte_t        value_out
);
    import psd_pkg::*;

    psd_byte_t held;
    psd_byte_t next_held;

    // ****************************************
    // next value
    // ****************************************
    always_comb
    begin
        // set wins over clear
        if (clear_in)
        begin
            next_held = event_in & MASK;
        end
        else
        begin
            next_held = (held | event_in) & MASK;
        end
    end

    // ****************************************
    // register
    // ****************************************
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            held <= `PSD_RESET_VALUE;
        end
        else
        begin
            held <= next_held;
        end
    end

    assign value_out = held;

endmodule // psd_sticky_byte

// ### testbench/psd_host_model.sv
// host model that issues status commands
`timescale 1ns/10ps

module psd_host_model
(
    output logic             cmd_valid_out,
    output logic             cmd_write_out,
    output logic [7:0]       cmd_code_out
);
    // ************************************************************
    // command issue
    // ************************************************************
    // start values set before any process runs, so no time-zero race
    logic        valid = 1'b0;
    logic        write = 1'b1;
    logic [7:0]  code = 8'h5a;

    assign cmd_valid_out = valid;
    assign cmd_write_out = write;
    assign cmd_code_out = code;

    // idle lines show the inverse of the last value
    task automatic issue(input logic v, input logic w, input logic [7:0] c);
        valid = v;
        write = v ? w : ~write;
        code = v ? c : ~code;
    endtask
endmodule // psd_host_model

// ### testbench/psd_status_bank_bench.sv
// self-checking bench of the detail status byte bank
`timescale 1ns/10ps
`include "psd_params.svh"

module psd_status_bank_bench;
    import psd_pkg::*;
    // ************************************************************
    // stimulus and model
    // ************************************************************
    logic         clk_in = 1'b0;
    logic         reset_in = 1'b1;
    logic [23:0]  ev = '0;
    logic         vend = 1'b0;
    logic         cv;
    logic         cw;
    logic [7:0]   cc;
    psd_byte_t    rd;
    psd_byte_t    st [5];
    logic         hit;
    logic         refused;
    logic         other;
    logic [31:0]  seed = 32'h7ec5b433;
    int           errors = 0;
    int           cmp_count = 0;
    int           cycles = 0;
    int           m [5];
    int           er;
    int           eh;
    int           ew;
    int           eo;
    logic [7:0]   codes [8] = '{`PSD_CMD_VOUT, `PSD_CMD_IOUT, `PSD_CMD_INPUT,
        `PSD_CMD_TEMP, `PSD_CMD_CML, `PSD_CMD_CLEAR, 8'h55, 8'h00};

    always #2 clk_in = ~clk_in;

    psd_status_bank i_psd_status_bank
    (
        .clk_in(clk_in), .reset_in(reset_in),
        .vout_uv_fault_in(ev[0]), .vout_uv_warning_in(ev[1]),
        .vout_ov_fault_in(ev[2]), .phase1_fault_in(ev[3]),
        .phase0_fault_in(ev[4]), .iout_uc_fault_in(ev[5]),
        .iout_oc_warning_in(ev[6]), .iout_low_voltage_in(ev[7]),
        .iout_oc_fault_in(ev[8]), .vin_uv_fault_in(ev[9]),
        .vin_uv_warning_in(ev[10]), .vin_ov_warning_in(ev[11]),
        .vin_ov_fault_in(ev[12]), .external_sensor_b_event_in(ev[13]),
        .external_sensor_a_event_in(ev[14]),
        .internal_sensor_event_in(ev[15]), .ut_fault_in(ev[16]),
        .ut_warning_in(ev[17]), .ot_warning_in(ev[18]),
        .ot_fault_in(ev[19]), .other_comm_fault_in(ev[20]),
        .packet_error_in(ev[21]), .bad_data_in(ev[22]),
        .bad_command_in(ev[23]), .cmd_valid_in(cv), .cmd_write_in(cw),
        .cmd_code_in(cc), .vendor_status_any_in(vend),
        .read_data_out(rd), .read_hit_out(hit),
        .write_refused_out(refused), .status_other_out(other),
        .output_voltage_status_out(st[0]),
        .output_current_status_out(st[1]),
        .input_supply_status_out(st[2]), .thermal_status_out(st[3]),
        .comm_logic_memory_status_out(st[4])
    );

    psd_host_model i_psd_host_model
    (
        .cmd_valid_out(cv), .cmd_write_out(cw), .cmd_code_out(cc)
    );

    function automatic logic [31:0] nx();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_reset;
        reset_in = 1'b1;
        ev = '0;
        vend = 1'b0;
        i_psd_host_model.issue(1'b0, 1'b0, 8'h00);
        repeat (2) @(posedge clk_in);
        #1;
        for (int i = 0; i < 5; i++)
            check("reset byte", st[i], `PSD_RESET_VALUE);
        m = '{0, 0, 0, 0, 0};
        er = 0;
        eh = 0;
        ew = 0;
        eo = 0;
        reset_in = 1'b0;
    endtask

    task automatic step;
        logic [31:0] rv;
        logic [7:0]  b [5];
        int          k;
        logic        v;
        logic        w;
        @(posedge clk_in);
        #1;
        check("read_data", rd, 8'(er));
        check("read_hit", {7'h0, hit}, 8'(eh));
        check("refused", {7'h0, refused}, 8'(ew));
        check("other", {7'h0, other}, 8'(eo));
        check("vout", st[0], 8'(m[0]));
        check("iout", st[1], 8'(m[1]));
        check("input", st[2], 8'(m[2]));
        check("thermal", st[3], 8'(m[3]));
        check("cml", st[4], 8'(m[4]));
        rv = nx();
        ev = 24'(nx() & nx() & nx() & nx());
        vend = rv[8] & rv[9];
        k = int'(rv[2:0]);
        v = (k != 7);
        w = (k == 5) | rv[3];
        b[0] = {ev[2], 1'b0, ev[1:0], 4'h0};
        b[1] = {ev[8], ev[8] & ev[7], ev[6:3], 2'b00};
        b[2] = {ev[12:9], 4'h0};
        b[3] = {ev[19:13], 1'b0};
        b[4] = {ev[23:21], 3'b000, ev[20], 1'b0};
        eh = (v && k < 5 && !w);
        ew = (v && k < 5 && w);
        er = eh ? m[k] : 0;
        eo = vend | ((m[0] | m[1] | m[2] | m[3] | m[4]) != 0);
        for (int i = 0; i < 5; i++)
            m[i] = (v && k == 5 ? 0 : m[i]) | b[i];
        if (ew != 0)
            m[4] = m[4] | 2;
        i_psd_host_model.issue(v, w, codes[k]);
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            errors++;
            final_report();
        end
    end

    initial
    begin
        for (int p = 0; p < 2; p++)
        begin
            do_reset();
            repeat (1500) step();
            // let the last command's edge pass before the next reset
            @(posedge clk_in);
            #1;
        end
        final_report();
    end
endmodule // psd_status_bank_bench

// ### testbench/psd_status_properties.sv
// port checker of the detail status byte bank
`timescale 1ns/10ps

module psd_status_properties
(
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    input  wire logic                vout_ov_fault_in,
    input  wire logic                vout_uv_warning_in,
    input  wire logic                vout_uv_fault_in,
    input  wire logic                iout_oc_fault_in,
    input  wire logic                iout_low_voltage_in,
    input  wire logic                external_sensor_b_event_in,
    input  wire logic                packet_error_in,
    input  wire logic                cmd_valid_in,
    input  wire logic                cmd_write_in,
    input  wire logic [7:0]          cmd_code_in,
    input  wire psd_pkg::psd_byte_t  read_data_out,
    input  wire logic                read_hit_out,
    input  wire logic                write_refused_out,
    input  wire logic                status_other_out,
    input  wire psd_pkg::psd_byte_t  output_voltage_status_out,
    input  wire psd_pkg::psd_byte_t  output_current_status_out,
    input  wire psd_pkg::psd_byte_t  input_supply_status_out,
    input  wire psd_pkg::psd_byte_t  thermal_status_out,
    input  wire psd_pkg::psd_byte_t  comm_logic_memory_status_out
);
    import psd_pkg::*;
    // ************************************************************
    // properties
    // ************************************************************
    logic clr;
    assign clr = cmd_valid_in && cmd_write_in && cmd_code_in == 8'h03;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    sequence rd_s;
        cmd_valid_in && !cmd_write_in && cmd_code_in == 8'h7a;
    endsequence
    sequence wr_s;
        cmd_valid_in && cmd_write_in && cmd_code_in inside {[8'h7a:8'h7e]};
    endsequence
    a_reset_zero: assert property ($fell(reset_in) |->
        output_current_status_out == 8'h00 && !read_hit_out)
        else $error("bank not zero after reset");
    a_read_vout: assert property (rd_s |=> read_hit_out &&
        read_data_out == $past(output_voltage_status_out))
        else $error("read of output voltage byte wrong");
    a_read_pulse: assert property (rd_s ##1 !cmd_valid_in |=>
        !read_hit_out) else $error("read hit not a pulse");
    a_vout_ov_set: assert property (vout_ov_fault_in |=>
        output_voltage_status_out[7]) else $error("ov bit not set");
    a_uv_pair: assert property (vout_uv_warning_in &&
        vout_uv_fault_in |=> output_voltage_status_out[5:4] == 2'b11)
        else $error("uv bits not set");
    a_unused_zero: assert property (((output_voltage_status_out & 8'h4f) |
        (output_current_status_out & 8'h03) | (input_supply_status_out &
        8'h0f) | (thermal_status_out & 8'h01) |
        (comm_logic_memory_status_out & 8'h1d)) == 8'h00)
        else $error("unused bit set");
    a_oc_lv_set: assert property (iout_oc_fault_in &&
        iout_low_voltage_in |=> output_current_status_out[7:6] == 2'b11)
        else $error("overcurrent bits not set");
    a_sensor_b: assert property (external_sensor_b_event_in |=>
        thermal_status_out[1]) else $error("sensor b bit not set");
    a_packet_err: assert property (packet_error_in |=>
        comm_logic_memory_status_out[5]) else $error("pec bit not set");
    a_write_refused: assert property (wr_s |=> write_refused_out &&
        comm_logic_memory_status_out[1]) else $error("write not refused");
    a_summary_bit: assert property (|comm_logic_memory_status_out |=>
        status_other_out) else $error("summary bit missing");
    a_sticky_hold: assert property (output_voltage_status_out[7] &&
        !clr |=> output_voltage_status_out[7]) else $error("ov bit lost");
    a_clear_vout: assert property (clr && !vout_ov_fault_in &&
        !vout_uv_warning_in && !vout_uv_fault_in |=>
        output_voltage_status_out == 8'h00) else $error("clear failed");
endmodule // psd_status_properties

bind psd_status_bank psd_status_properties i_psd_status_properties
(
    .clk_in(clk_in), .reset_in(reset_in),
    .vout_ov_fault_in(vout_ov_fault_in),
    .vout_uv_warning_in(vout_uv_warning_in),
    .vout_uv_fault_in(vout_uv_fault_in),
    .iout_oc_fault_in(iout_oc_fault_in),
    .iout_low_voltage_in(iout_low_voltage_in),
    .external_sensor_b_event_in(external_sensor_b_event_in),
    .packet_error_in(packet_error_in), .cmd_valid_in(cmd_valid_in),
    .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in),
    .read_data_out(read_data_out), .read_hit_out(read_hit_out),
    .write_refused_out(write_refused_out),
    .status_other_out(status_other_out),
    .output_voltage_status_out(output_voltage_status_out),
    .output_current_status_out(output_current_status_out),
    .input_supply_status_out(input_supply_status_out),
    .thermal_status_out(thermal_status_out),
    .comm_logic_memory_status_out(comm_logic_memory_status_out)
);
